//--- hdl/ipf_consts.vh
`ifndef IPF_CONSTS_VH
`define IPF_CONSTS_VH

// field shape
`define IPF_LVL_W          3
`define IPF_LVL_RST        3'h4
`define IPF_NSRC           19
`define IPF_LVL_VEC_W      57
`define IPF_REG_W          16

// register indices; byte address is four times the index
`define IPF_IDX_CAPCOMP1_CALENDAR   10'h0C6
`define IPF_IDX_CRC_SERIAL_CAPCOMP2 10'h0C8
`define IPF_IDX_VOLTAGE_DETECT      10'h0CC
`define IPF_IDX_USB_BUS_COLLISIONS  10'h0D2
`define IPF_IDX_CAPCOMP3_CAPCOMP4   10'h0D6
`define IPF_IDX_LOGIC_CELLS         10'h0D8
`define IPF_IDX_OSC_SELFTUNE        10'h0DC
`define IPF_IDX_CALENDAR_TIMESTAMP  10'h0DE
`define IPF_IDX_DEBUG_PORT          10'h0E2

// field low bit positions inside a register
`define IPF_LSB_14_12      4'hC
`define IPF_LSB_10_8       4'h8
`define IPF_LSB_6_4        4'h4
`define IPF_LSB_2_0        4'h0

// source numbering in the packed level vector
`define IPF_SRC_CAPCOMP1           5'h00
`define IPF_SRC_CALENDAR           5'h01
`define IPF_SRC_CHECKSUM_GEN       5'h02
`define IPF_SRC_SERIAL2_ERROR      5'h03
`define IPF_SRC_SERIAL1_ERROR      5'h04
`define IPF_SRC_CAPCOMP2           5'h05
`define IPF_SRC_VOLTAGE_DETECT     5'h06
`define IPF_SRC_USB_CTRL           5'h07
`define IPF_SRC_TWOWIRE2_COLL      5'h08
`define IPF_SRC_TWOWIRE1_COLL      5'h09
`define IPF_SRC_CAPCOMP4           5'h0A
`define IPF_SRC_CAPCOMP3           5'h0B
`define IPF_SRC_LOGIC_CELL4        5'h0C
`define IPF_SRC_LOGIC_CELL3        5'h0D
`define IPF_SRC_LOGIC_CELL2        5'h0E
`define IPF_SRC_LOGIC_CELL1        5'h0F
`define IPF_SRC_OSC_SELFTUNE       5'h10
`define IPF_SRC_CAL_TIMESTAMP      5'h11
`define IPF_SRC_DEBUG_PORT         5'h12

`endif

//--- hdl/ipf_arbiter.v
`timescale 1ns/10ps
`default_nettype none
`include "ipf_consts.vh"

module ipf_arbiter (
  input  wire                       pclk,
  input  wire                       presetn,
  input  wire [`IPF_NSRC-1:0]       pending,
  input  wire [`IPF_LVL_VEC_W-1:0]  levels,
  input  wire [3:0]                 cpu_level,
  output reg                        req_q,
  output reg  [4:0]                 src_q,
  output reg  [`IPF_LVL_W-1:0]      lvl_q
);

  reg  [`IPF_LVL_W-1:0] best_lvl;
  reg  [4:0]            best_src;
  reg                   req_d;
  integer               i;

  // strict compare keeps the lowest-numbered source on a tie;
  // starting from level 0 means a level-0 source is never picked
  always @* begin
    best_lvl = 3'h0;
    best_src = 5'h00;
    for (i = 0; i < `IPF_NSRC; i = i + 1) begin
      if (pending[i] && (levels[i*3 +: 3] > best_lvl)) begin
        best_lvl = levels[i*3 +: 3];
        best_src = i[4:0];
      end
    end
    req_d = ({1'b0, best_lvl} > cpu_level);
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      src_q <= 5'h00;
      lvl_q <= 3'h0;
    end else begin
      req_q <= req_d;
      src_q <= req_d ? best_src : 5'h00;
      lvl_q <= req_d ? best_lvl : 3'h0;
    end
  end

endmodule // ipf_arbiter

`default_nettype wire

//--- hdl/ipf_top.v
`timescale 1ns/10ps
`default_nettype none
`include "ipf_consts.vh"

// Functional notes
// - three-bit level per source, 7 highest
// - every field resets to level 4
// - reg C6: capcomp1 14:12, calendar 10:8
// - reg C8: crc, serial2, serial1, capcomp2
// - reg CC: voltage detect in 2:0 only
// - reg D2: usb 10:8, twowire2 6:4, twowire1 2:0
// - reg D6: capcomp4 14:12, capcomp3 10:8
// - reg D8: logic cells 4..1, high to low
// - reg DC: oscillator self-tune in 10:8 only
// - reg DE: calendar timestamp in 10:8 only
// - reg E2: debug port in 6:4 only
// - request only when level exceeds cpu level
module ipf_top (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [`IPF_NSRC-1:0]   src_pending,
  input  wire [3:0]             cpu_level,
  output wire                   irq_req,
  output wire [4:0]             irq_src,
  output wire [2:0]             irq_level,
  output wire [2:0]             capcomp1_level,
  output wire [2:0]             calendar_level,
  output wire [2:0]             checksum_gen_level,
  output wire [2:0]             serial2_error_level,
  output wire [2:0]             serial1_error_level,
  output wire [2:0]             capcomp2_level,
  output wire [2:0]             voltage_detect_level,
  output wire [2:0]             usb_ctrl_level,
  output wire [2:0]             twowire2_collision_level,
  output wire [2:0]             twowire1_collision_level,
  output wire [2:0]             capcomp4_level,
  output wire [2:0]             capcomp3_level,
  output wire [2:0]             logic_cell4_level,
  output wire [2:0]             logic_cell3_level,
  output wire [2:0]             logic_cell2_level,
  output wire [2:0]             logic_cell1_level,
  output wire [2:0]             osc_selftune_level,
  output wire [2:0]             calendar_timestamp_level,
  output wire [2:0]             debug_port_level
);

  // ------------------------------------------------------------------
  // field map: which register and which bit position hold each source
  // ------------------------------------------------------------------
  function [9:0] field_reg;
    input [4:0] s;
    begin
      case (s)
        `IPF_SRC_CAPCOMP1,
        `IPF_SRC_CALENDAR:       field_reg = `IPF_IDX_CAPCOMP1_CALENDAR;
        `IPF_SRC_CHECKSUM_GEN,
        `IPF_SRC_SERIAL2_ERROR,
        `IPF_SRC_SERIAL1_ERROR,
        `IPF_SRC_CAPCOMP2:       field_reg = `IPF_IDX_CRC_SERIAL_CAPCOMP2;
        `IPF_SRC_VOLTAGE_DETECT: field_reg = `IPF_IDX_VOLTAGE_DETECT;
        `IPF_SRC_USB_CTRL,
        `IPF_SRC_TWOWIRE2_COLL,
        `IPF_SRC_TWOWIRE1_COLL:  field_reg = `IPF_IDX_USB_BUS_COLLISIONS;
        `IPF_SRC_CAPCOMP4,
        `IPF_SRC_CAPCOMP3:       field_reg = `IPF_IDX_CAPCOMP3_CAPCOMP4;
        `IPF_SRC_LOGIC_CELL4,
        `IPF_SRC_LOGIC_CELL3,
        `IPF_SRC_LOGIC_CELL2,
        `IPF_SRC_LOGIC_CELL1:    field_reg = `IPF_IDX_LOGIC_CELLS;
        `IPF_SRC_OSC_SELFTUNE:   field_reg = `IPF_IDX_OSC_SELFTUNE;
        `IPF_SRC_CAL_TIMESTAMP:  field_reg = `IPF_IDX_CALENDAR_TIMESTAMP;
        `IPF_SRC_DEBUG_PORT:     field_reg = `IPF_IDX_DEBUG_PORT;
        default:                 field_reg = 10'h3FF;
      endcase
    end
  endfunction

  function [3:0] field_lsb;
    input [4:0] s;
    begin
      case (s)
        `IPF_SRC_CAPCOMP1,
        `IPF_SRC_CHECKSUM_GEN,
        `IPF_SRC_CAPCOMP4,
        `IPF_SRC_LOGIC_CELL4:    field_lsb = `IPF_LSB_14_12;
        `IPF_SRC_CALENDAR,
        `IPF_SRC_SERIAL2_ERROR,
        `IPF_SRC_USB_CTRL,
        `IPF_SRC_CAPCOMP3,
        `IPF_SRC_LOGIC_CELL3,
        `IPF_SRC_OSC_SELFTUNE,
        `IPF_SRC_CAL_TIMESTAMP:  field_lsb = `IPF_LSB_10_8;
        `IPF_SRC_SERIAL1_ERROR,
        `IPF_SRC_TWOWIRE2_COLL,
        `IPF_SRC_LOGIC_CELL2,
        `IPF_SRC_DEBUG_PORT:     field_lsb = `IPF_LSB_6_4;
        default:                 field_lsb = `IPF_LSB_2_0;
      endcase
    end
  endfunction

  // an index belongs to the block when some field lives there
  function reg_mapped;
    input [9:0] idx;
    begin
      case (idx)
        `IPF_IDX_CAPCOMP1_CALENDAR,
        `IPF_IDX_CRC_SERIAL_CAPCOMP2,
        `IPF_IDX_VOLTAGE_DETECT,
        `IPF_IDX_USB_BUS_COLLISIONS,
        `IPF_IDX_CAPCOMP3_CAPCOMP4,
        `IPF_IDX_LOGIC_CELLS,
        `IPF_IDX_OSC_SELFTUNE,
        `IPF_IDX_CALENDAR_TIMESTAMP,
        `IPF_IDX_DEBUG_PORT:     reg_mapped = 1'b1;
        default:                 reg_mapped = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg  [`IPF_LVL_VEC_W-1:0] lvl_q;
  reg  [`IPF_LVL_VEC_W-1:0] lvl_d;
  reg  [`IPF_REG_W-1:0]     rd_word;
  reg  [31:0]               prdata_d;
  reg                       pready_d;
  reg                       pslverr_d;
  wire [9:0]                reg_idx;
  wire                      addr_ok;
  wire                      setup_ph;
  wire                      wr_fire;
  integer                   i;

  assign reg_idx  = paddr[11:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) && reg_mapped(reg_idx);
  assign setup_ph = psel && !penable;
  // a write lands only at the completing access edge
  assign wr_fire  = psel && penable && pready && pwrite && addr_ok;

  // ------------------------------------------------------------------
  // field write path
  // ------------------------------------------------------------------
  // each field sits wholly in one byte lane, so its strobe alone gates it;
  // bits outside any field have no storage, hence writes there vanish
  always @* begin
    lvl_d = lvl_q;
    if (wr_fire) begin
      case (reg_idx)
        `IPF_IDX_CAPCOMP1_CALENDAR: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_CAPCOMP1*3 +: 3]      = pwdata[`IPF_LSB_14_12 +: 3];
            lvl_d[`IPF_SRC_CALENDAR*3 +: 3]      = pwdata[`IPF_LSB_10_8 +: 3];
          end
        end
        `IPF_IDX_CRC_SERIAL_CAPCOMP2: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_CHECKSUM_GEN*3 +: 3]  = pwdata[`IPF_LSB_14_12 +: 3];
            lvl_d[`IPF_SRC_SERIAL2_ERROR*3 +: 3] = pwdata[`IPF_LSB_10_8 +: 3];
          end
          if (pstrb[0]) begin
            lvl_d[`IPF_SRC_SERIAL1_ERROR*3 +: 3] = pwdata[`IPF_LSB_6_4 +: 3];
            lvl_d[`IPF_SRC_CAPCOMP2*3 +: 3]      = pwdata[`IPF_LSB_2_0 +: 3];
          end
        end
        `IPF_IDX_VOLTAGE_DETECT: begin
          if (pstrb[0]) begin
            lvl_d[`IPF_SRC_VOLTAGE_DETECT*3 +: 3] = pwdata[`IPF_LSB_2_0 +: 3];
          end
        end
        `IPF_IDX_USB_BUS_COLLISIONS: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_USB_CTRL*3 +: 3]      = pwdata[`IPF_LSB_10_8 +: 3];
          end
          if (pstrb[0]) begin
            lvl_d[`IPF_SRC_TWOWIRE2_COLL*3 +: 3] = pwdata[`IPF_LSB_6_4 +: 3];
            lvl_d[`IPF_SRC_TWOWIRE1_COLL*3 +: 3] = pwdata[`IPF_LSB_2_0 +: 3];
          end
        end
        `IPF_IDX_CAPCOMP3_CAPCOMP4: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_CAPCOMP4*3 +: 3]      = pwdata[`IPF_LSB_14_12 +: 3];
            lvl_d[`IPF_SRC_CAPCOMP3*3 +: 3]      = pwdata[`IPF_LSB_10_8 +: 3];
          end
        end
        `IPF_IDX_LOGIC_CELLS: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_LOGIC_CELL4*3 +: 3]   = pwdata[`IPF_LSB_14_12 +: 3];
            lvl_d[`IPF_SRC_LOGIC_CELL3*3 +: 3]   = pwdata[`IPF_LSB_10_8 +: 3];
          end
          if (pstrb[0]) begin
            lvl_d[`IPF_SRC_LOGIC_CELL2*3 +: 3]   = pwdata[`IPF_LSB_6_4 +: 3];
            lvl_d[`IPF_SRC_LOGIC_CELL1*3 +: 3]   = pwdata[`IPF_LSB_2_0 +: 3];
          end
        end
        `IPF_IDX_OSC_SELFTUNE: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_OSC_SELFTUNE*3 +: 3]  = pwdata[`IPF_LSB_10_8 +: 3];
          end
        end
        `IPF_IDX_CALENDAR_TIMESTAMP: begin
          if (pstrb[1]) begin
            lvl_d[`IPF_SRC_CAL_TIMESTAMP*3 +: 3] = pwdata[`IPF_LSB_10_8 +: 3];
          end
        end
        `IPF_IDX_DEBUG_PORT: begin
          if (pstrb[0]) begin
            lvl_d[`IPF_SRC_DEBUG_PORT*3 +: 3]    = pwdata[`IPF_LSB_6_4 +: 3];
          end
        end
        default: lvl_d = lvl_q;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= {`IPF_NSRC{`IPF_LVL_RST}};
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // ------------------------------------------------------------------
  // read path and bus answer
  // ------------------------------------------------------------------
  // read data is captured in the setup cycle so that prdata is a flop;
  // pready is then high in the first access cycle, so no transfer has a wait state
  always @* begin
    rd_word = 16'h0000;
    for (i = 0; i < `IPF_NSRC; i = i + 1) begin
      if (field_reg(i[4:0]) == reg_idx) begin
        rd_word[field_lsb(i[4:0]) +: 3] = lvl_q[i*3 +: 3];
      end
    end
    pready_d  = setup_ph;
    pslverr_d = setup_ph && !addr_ok;
    if (setup_ph && !pwrite && addr_ok) begin
      prdata_d = {16'h0000, rd_word};
    end else if (setup_ph) begin
      prdata_d = 32'h0000_0000;
    end else begin
      prdata_d = prdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ------------------------------------------------------------------
  // level outputs, straight from the field flops
  // ------------------------------------------------------------------
  assign capcomp1_level           = lvl_q[`IPF_SRC_CAPCOMP1*3 +: 3];
  assign calendar_level           = lvl_q[`IPF_SRC_CALENDAR*3 +: 3];
  assign checksum_gen_level       = lvl_q[`IPF_SRC_CHECKSUM_GEN*3 +: 3];
  assign serial2_error_level      = lvl_q[`IPF_SRC_SERIAL2_ERROR*3 +: 3];
  assign serial1_error_level      = lvl_q[`IPF_SRC_SERIAL1_ERROR*3 +: 3];
  assign capcomp2_level           = lvl_q[`IPF_SRC_CAPCOMP2*3 +: 3];
  assign voltage_detect_level     = lvl_q[`IPF_SRC_VOLTAGE_DETECT*3 +: 3];
  assign usb_ctrl_level           = lvl_q[`IPF_SRC_USB_CTRL*3 +: 3];
  assign twowire2_collision_level = lvl_q[`IPF_SRC_TWOWIRE2_COLL*3 +: 3];
  assign twowire1_collision_level = lvl_q[`IPF_SRC_TWOWIRE1_COLL*3 +: 3];
  assign capcomp4_level           = lvl_q[`IPF_SRC_CAPCOMP4*3 +: 3];
  assign capcomp3_level           = lvl_q[`IPF_SRC_CAPCOMP3*3 +: 3];
  assign logic_cell4_level        = lvl_q[`IPF_SRC_LOGIC_CELL4*3 +: 3];
  assign logic_cell3_level        = lvl_q[`IPF_SRC_LOGIC_CELL3*3 +: 3];
  assign logic_cell2_level        = lvl_q[`IPF_SRC_LOGIC_CELL2*3 +: 3];
  assign logic_cell1_level        = lvl_q[`IPF_SRC_LOGIC_CELL1*3 +: 3];
  assign osc_selftune_level       = lvl_q[`IPF_SRC_OSC_SELFTUNE*3 +: 3];
  assign calendar_timestamp_level = lvl_q[`IPF_SRC_CAL_TIMESTAMP*3 +: 3];
  assign debug_port_level         = lvl_q[`IPF_SRC_DEBUG_PORT*3 +: 3];

  // ------------------------------------------------------------------
  // comparison against the processor level
  // ------------------------------------------------------------------
  // pending and cpu_level come from logic on pclk, so no synchroniser
  ipf_arbiter u_arb (
    .pclk      (pclk),
    .presetn   (presetn),
    .pending   (src_pending),
    .levels    (lvl_q),
    .cpu_level (cpu_level),
    .req_q     (irq_req),
    .src_q     (irq_src),
    .lvl_q     (irq_level)
  );

endmodule // ipf_top

`default_nettype wire

//--- verif/ipf_props.sv
`timescale 1ns/10ps
`default_nettype none
module ipf_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  cpu_level,
  input wire logic        irq_req,
  input wire logic [4:0]  irq_src,
  input wire logic [2:0]  irq_level,
  input wire logic [2:0]  capcomp1_level,
  input wire logic [2:0]  debug_port_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst_lvl; $rose(presetn) |-> capcomp1_level == 3'h4 && debug_port_level == 3'h4; endproperty
  a_rst_lvl: assert property (p_rst_lvl) else $error("level not default after reset");
  property p_setup_rdy; psel && !penable |=> pready; endproperty
  a_setup_rdy: assert property (p_setup_rdy) else $error("no ready after setup");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  property p_rd_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_req_gt; irq_req |-> irq_level > $past(cpu_level); endproperty
  a_req_gt: assert property (p_req_gt) else $error("request at or below cpu level");
  property p_no_zero; irq_req |-> irq_level != 3'h0; endproperty
  a_no_zero: assert property (p_no_zero) else $error("level zero source requested");
  property p_idle_out; !irq_req |-> irq_src == 5'h00 && irq_level == 3'h0; endproperty
  a_idle_out: assert property (p_idle_out) else $error("winner shown without request");
  property p_lvl_wr; !$stable(capcomp1_level) |-> $past(psel && penable && pwrite && pready); endproperty
  a_lvl_wr: assert property (p_lvl_wr) else $error("level moved without a write");
endmodule // ipf_props
bind ipf_top ipf_props i_ipf_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata), .cpu_level(cpu_level),
  .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level), .capcomp1_level(capcomp1_level),
  .debug_port_level(debug_port_level));
`default_nettype wire

//--- verif/interrupt_priority_fields_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_fields_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'hF, cpu_level = 4'h0;
  logic [18:0] src_pending = 19'h0;
  wire         pready, pslverr, irq_req;
  wire  [31:0] prdata;
  wire  [4:0]  irq_src;
  wire  [2:0]  irq_level;
  wire  [2:0]  f [19];
  wire  [15:0] lv [9];
  int          n_errors = 0, n_checks = 0;
  logic [11:0] ad [9] = '{12'h318, 12'h320, 12'h330, 12'h348, 12'h358, 12'h360, 12'h370, 12'h378, 12'h388};
  logic [15:0] mk [9] = '{16'h7700, 16'h7777, 16'h0007, 16'h0777, 16'h7700, 16'h7777, 16'h0700, 16'h0700, 16'h0070};
  logic [31:0] pat [2] = '{32'hFFFF_1357, 32'hFFFF_EDCB};

  always #2.5 pclk = ~pclk;

  ipf_top i_ipf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_pending(src_pending), .cpu_level(cpu_level), .irq_req(irq_req), .irq_src(irq_src),
    .irq_level(irq_level), .capcomp1_level(f[0]), .calendar_level(f[1]), .checksum_gen_level(f[2]),
    .serial2_error_level(f[3]), .serial1_error_level(f[4]), .capcomp2_level(f[5]),
    .voltage_detect_level(f[6]), .usb_ctrl_level(f[7]), .twowire2_collision_level(f[8]),
    .twowire1_collision_level(f[9]), .capcomp4_level(f[10]), .capcomp3_level(f[11]),
    .logic_cell4_level(f[12]), .logic_cell3_level(f[13]), .logic_cell2_level(f[14]),
    .logic_cell1_level(f[15]), .osc_selftune_level(f[16]), .calendar_timestamp_level(f[17]),
    .debug_port_level(f[18]));

  // level ports regrouped into register layout so bus and ports compare alike
  assign lv[0] = {1'b0, f[0], 1'b0, f[1], 8'h00};
  assign lv[1] = {1'b0, f[2], 1'b0, f[3], 1'b0, f[4], 1'b0, f[5]};
  assign lv[2] = {13'h0000, f[6]};
  assign lv[3] = {5'h00, f[7], 1'b0, f[8], 1'b0, f[9]};
  assign lv[4] = {1'b0, f[10], 1'b0, f[11], 8'h00};
  assign lv[5] = {1'b0, f[12], 1'b0, f[13], 1'b0, f[14], 1'b0, f[15]};
  assign lv[6] = {5'h00, f[16], 8'h00};
  assign lv[7] = {5'h00, f[17], 8'h00};
  assign lv[8] = {9'h000, f[18], 4'h0};

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task results;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, data and error are all taken at the rising edge that completes the access
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task arb(input logic [18:0] p, input logic [3:0] c, input logic [8:0] e);
    @(posedge pclk);
    src_pending <= p;
    cpu_level <= c;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({irq_req, irq_src, irq_level}, e);
  endtask

  task t_reset;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ad[i], 32'h0, 4'hF);
      chk(rd, mk[i] & 16'h4444);
      chk(lv[i], mk[i] & 16'h4444);
    end
  endtask

  task t_arb;
    arb(19'h00028, 4'h3, {1'b1, 5'h03, 3'h4});
    arb(19'h00028, 4'h4, 9'h000);
    apb(1'b1, 12'h320, 32'h0000_4447, 4'hF);
    arb(19'h00028, 4'h6, {1'b1, 5'h05, 3'h7});
  endtask

  task t_fields;
    logic [15:0] e;
    for (int i = 0; i < 9; i++) begin
      for (int j = 0; j < 2; j++) begin
        apb(1'b1, ad[i], pat[j], 4'hF);
        apb(1'b0, ad[i], 32'h0, 4'hF);
        e = pat[j][15:0] & mk[i];
        chk(rd, {16'h0000, e});
        chk(lv[i], e);
      end
      apb(1'b1, ad[i], 32'h0, 4'h2);
      chk(lv[i], e & 16'h00FF);
      apb(1'b1, ad[i], 32'h0, 4'h1);
      chk(lv[i], 32'h0);
    end
  endtask

  task t_refuse;
    apb(1'b1, 12'h31C, 32'hFFFF_FFFF, 4'hF);
    chk(err, 1'b1);
    apb(1'b1, 12'h31A, 32'hFFFF_FFFF, 4'hF);
    chk(err, 1'b1);
    apb(1'b0, 12'h319, 32'h0, 4'hF);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h318, 32'h0, 4'hF);
    chk(err, 1'b0);
    chk(rd, 32'h0);
    // all levels are now zero: nothing may win even at cpu level 0
    arb(19'h7FFFF, 4'h0, 9'h000);
    apb(1'b1, 12'h360, 32'h0000_0001, 4'hF);
    arb(19'h7FFFF, 4'h0, {1'b1, 5'h0F, 3'h1});
  endtask

  initial begin
    #100000;
    n_errors++;
    results;
  end

  initial begin
    do_reset;
    t_reset;
    t_arb;
    t_fields;
    t_refuse;
    @(posedge pclk);
    do_reset;
    t_reset;
    results;
  end
endmodule // interrupt_priority_fields_tb
`default_nettype wire
